/* verilog/its_defs.svh */
// Purpose: Constants for the ignition timing schedule block.
// Assumes: Angles are signed 0.1 degree steps before top center (advance positive).
// Notes:   Current levels in uA, voltage levels in mV, speeds in rpm.
//
// Behaviour
// RULE1 - Schedule select input level chooses first or second schedule.
// RULE2 - With only one schedule enabled, select input is ignored.
// RULE3 - Software keeps at least one schedule enabled at all times.
// RULE4 - Second schedule has exactly the same parameters as the first.
// RULE5 - Each output firing point clamped into the min/max timing window.
// RULE6 - Summed global timing saturates at the window bounds.
// RULE7 - Base timing lies in the window and is the static component.
// RULE8 - Potentiometer moves timing toward advance or retard endpoint by rotation direction.
// RULE9 - Potentiometer enable changes take effect only after engine restart.
// RULE10 - Current and voltage inputs individually enabled, interpolated between their endpoints.
// RULE11 - Below failure threshold, the error value replaces that input's adjustment.
// RULE12 - Error offset stays until signal rises above the lower limit.
// RULE13 - Error fallback only usable when a failure threshold is configured.
// RULE14 - Per-cylinder offsets clamped to advance and retard individual limits.
// RULE15 - Speed curve individually enabled, one to eight points.
// RULE16 - First speed curve point is fixed at zero rpm.
// RULE17 - Each further point applies its offset once speed reaches it.
// RULE18 - Software supplies strictly ascending speed point values.
// RULE19 - Last point should carry the nominal speed timing.
// RULE20 - Input below failure threshold is classified as failed.
// RULE21 - Global timing is base plus enabled signed offsets, before clamping.
// RULE22 - Offsets interpolated linearly between curve points and analog limits.
`ifndef ITS_DEFS_SVH
`define ITS_DEFS_SVH

// ==========================================================================
// Schedule word indices (address bit 6 picks the schedule)
`define ITS_S_CTRL      5'h00
`define ITS_S_WIN_P1    5'h01
`define ITS_S_WIN_P2    5'h02
`define ITS_S_BASE      5'h03
`define ITS_S_POT_CW    5'h04
`define ITS_S_POT_CCW   5'h05
`define ITS_S_CUR_LO    5'h06
`define ITS_S_CUR_HI    5'h07
`define ITS_S_CUR_ERR   5'h08
`define ITS_S_VOLT_LO   5'h09
`define ITS_S_VOLT_HI   5'h0A
`define ITS_S_VOLT_ERR  5'h0B
`define ITS_S_IND_ADV   5'h0C
`define ITS_S_IND_RET   5'h0D
`define ITS_S_SPD0      5'h10
`define ITS_S_TIM0      5'h18

// ==========================================================================
// Control word fields
`define ITS_EN_BIT      0
`define ITS_POT_BIT     1
`define ITS_CUR_BIT     2
`define ITS_VOLT_BIT    3
`define ITS_CURVE_BIT   4
`define ITS_NPT_LSB     8
`define ITS_NPT_MSB     10

// ==========================================================================
// Global registers (address bit 7 set)
`define ITS_G_CUR_LO    8'h80
`define ITS_G_CUR_HI    8'h81
`define ITS_G_CUR_FAIL  8'h82
`define ITS_G_VOLT_LO   8'h83
`define ITS_G_VOLT_HI   8'h84
`define ITS_G_VOLT_FAIL 8'h85
`define ITS_G_TIMING    8'h86
`define ITS_G_STATUS    8'h87

// ==========================================================================
// Reset values
`define ITS_CTRL_A_RST  16'h0001
`define ITS_CTRL_B_RST  16'h0000
`define ITS_CUR_LO_RST  16'h0FA0
`define ITS_CUR_HI_RST  16'h4E20
`define ITS_VOLT_LO_RST 16'h0000
`define ITS_VOLT_HI_RST 16'h1388
`define ITS_FAIL_RST    16'h0000
`define ITS_POT_SHIFT   7

`endif

/* verilog/its_pkg.sv */
// Purpose: Types shared by the ignition timing schedule block.
// Assumes: Angles are signed 0.1 degree steps.
// Notes:   Constants live in its_defs.svh.
package its_pkg;
  typedef logic signed [15:0] its_deg_t;
  typedef logic signed [19:0] its_sum_t;
  typedef enum logic {
    ITS_SCHED_A = 1'b0,
    ITS_SCHED_B = 1'b1
  } its_sched_t;
endpackage

/* verilog/its_interp.sv */
// Purpose: Linear interpolation of an angle between two breakpoints.
// Assumes: x1 >= x0 whenever x lies strictly between them.
// Notes:   Purely combinational; outside the span the end value holds.
module its_interp
  import its_pkg::*;
(
  input  wire logic [15:0] x,
  input  wire logic [15:0] x0,
  input  wire logic [15:0] x1,
  input  wire its_deg_t    y0,
  input  wire its_deg_t    y1,
  output its_deg_t         y
);
  logic signed [16:0] dx;
  logic signed [16:0] span;
  logic signed [16:0] dy;
  logic signed [33:0] prod;
  logic signed [33:0] quot;

  assign dx   = $signed({1'b0, x}) - $signed({1'b0, x0});
  assign span = $signed({1'b0, x1}) - $signed({1'b0, x0});
  assign dy   = 17'(y1) - 17'(y0);
  assign prod = 34'(dx) * 34'(dy);
  // Division only taken when span is positive, so no divide by zero
  assign quot = (span > 17'sh00000) ? prod / 34'(span) : 34'sh000000000;

  // Ends hold their value; between them a straight line [RULE22]
  assign y = (x <= x0) ? y0 :
             (x >= x1) ? y1 :
             its_deg_t'(17'(y0) + 17'(quot));
endmodule

/* verilog/its_top.sv */
// Purpose: Global ignition timing from one of two schedules, plus clamped
//          firing points for each cylinder.
// Assumes: All inputs synchronous to mclk; engine_rpm of zero means standstill.
// Notes:   Register read data appear the cycle after the read strobe.
`include "its_defs.svh"

module its_top
  import its_pkg::*;
#(
  parameter int NCYL = 4
)(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [15:0]          reg_rdata,
  input  wire logic                 sched_sel,
  input  wire logic signed [7:0]    pot_pos,
  input  wire logic [15:0]          cur_level,
  input  wire logic [15:0]          volt_level,
  input  wire logic [15:0]          engine_rpm,
  input  wire logic [NCYL*16-1:0]   cyl_offset,
  output logic      [15:0]          global_timing,
  output logic      [NCYL*16-1:0]   fire_point,
  output logic                      sched_b_active,
  output logic                      cur_failed,
  output logic                      volt_failed
);

  // ========================================================================
  // Register storage
  // Both schedules share one layout so B offers exactly what A offers [RULE4]
  logic [15:0] sched_ff [2][32];
  logic [15:0] glob_ff  [6];
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic        sched_b_ff;
  logic [1:0]  pot_live_ff;
  logic        cur_fail_ff;
  logic        volt_fail_ff;
  logic [15:0] timing_ff;
  logic [NCYL*16-1:0] fire_ff;

  wire         sel_glob  = reg_addr[7];
  wire         sel_sched = ~reg_addr[7] & ~reg_addr[5];
  wire         glob_wr_ok = sel_glob & (reg_addr[6:3] == 4'h0) & (reg_addr[2:0] < 3'h6);
  wire [2:0]   gidx      = reg_addr[2:0];
  wire [4:0]   sidx      = reg_addr[4:0];
  wire         sb        = reg_addr[6];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < 2; s++) begin
        for (int i = 0; i < 32; i++) begin
          sched_ff[s][i] <= 16'h0000;
        end
      end
      sched_ff[0][`ITS_S_CTRL] <= `ITS_CTRL_A_RST;
      sched_ff[1][`ITS_S_CTRL] <= `ITS_CTRL_B_RST;
    end else if (reg_wr && sel_sched) begin
      sched_ff[sb][sidx] <= reg_wdata;
    end
  end

  // Read-only words sit outside glob_wr_ok, so writes to them fall away
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      glob_ff[0] <= `ITS_CUR_LO_RST;
      glob_ff[1] <= `ITS_CUR_HI_RST;
      glob_ff[2] <= `ITS_FAIL_RST;
      glob_ff[3] <= `ITS_VOLT_LO_RST;
      glob_ff[4] <= `ITS_VOLT_HI_RST;
      glob_ff[5] <= `ITS_FAIL_RST;
    end else if (reg_wr && glob_wr_ok) begin
      glob_ff[gidx] <= reg_wdata;
    end
  end

  // ========================================================================
  // Read path
  wire [15:0] status_word = {11'h000, pot_live_ff[sched_b_ff], volt_fail_ff,
                             cur_fail_ff, 1'b0, sched_b_ff};
  // The first speed point always reads back as zero rpm [RULE16]
  wire [15:0] sched_rd = (sidx == `ITS_S_SPD0) ? 16'h0000 : sched_ff[sb][sidx];

  wire        rd_timing = (reg_addr == `ITS_G_TIMING);
  wire        rd_status = (reg_addr == `ITS_G_STATUS);

  assign nxt_rdata = !reg_rd    ? rdata_ff :
                     sel_sched  ? sched_rd :
                     glob_wr_ok ? glob_ff[gidx] :
                     rd_timing  ? timing_ff :
                     rd_status  ? status_word :
                     16'h0000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= reg_rd ? nxt_rdata : 16'h0000;
    end
  end

  assign reg_rdata = rdata_ff;

  // ========================================================================
  // Schedule selection
  wire en_a = sched_ff[0][`ITS_S_CTRL][`ITS_EN_BIT];
  wire en_b = sched_ff[1][`ITS_S_CTRL][`ITS_EN_BIT];
  // Both off is a software fault; schedule A is then used as a safe fallback
  wire use_b = (en_a & en_b) ? sched_sel : (en_b & ~en_a); // [RULE1] [RULE2] [RULE3]
  its_sched_t act;
  assign act = use_b ? ITS_SCHED_B : ITS_SCHED_A;

  wire [15:0] ctrl     = sched_ff[act][`ITS_S_CTRL];
  wire        cur_en   = ctrl[`ITS_CUR_BIT];
  wire        volt_en  = ctrl[`ITS_VOLT_BIT];
  wire        curve_en = ctrl[`ITS_CURVE_BIT];
  wire [3:0]  npts     = {1'b0, ctrl[`ITS_NPT_MSB:`ITS_NPT_LSB]} + 4'h1;

  // Pot enable is only taken over at standstill, so a change made while
  // running waits for the next restart [RULE9]
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pot_live_ff <= 2'b00;
    end else if (engine_rpm == 16'h0000) begin
      pot_live_ff <= {sched_ff[1][`ITS_S_CTRL][`ITS_POT_BIT],
                      sched_ff[0][`ITS_S_CTRL][`ITS_POT_BIT]};
    end
  end

  // ========================================================================
  // Potentiometer
  wire [8:0]  pot_mag = pot_pos[7] ? 9'(-$signed({pot_pos[7], pot_pos})) : {1'b0, pot_pos};
  wire its_deg_t pot_end = pot_pos[7] ? its_deg_t'(sched_ff[act][`ITS_S_POT_CCW])
                                      : its_deg_t'(sched_ff[act][`ITS_S_POT_CW]);
  wire signed [25:0] pot_prod = $signed({17'h00000, pot_mag}) * 26'(pot_end);
  // Full CCW deflection (-128) reaches the CCW endpoint; full CW (+127) reaches 127/128 of the CW endpoint [RULE8]
  wire its_deg_t pot_adj = its_deg_t'(pot_prod >>> `ITS_POT_SHIFT);

  // ========================================================================
  // Analog failure detection
  wire cur_armed  = cur_en & (glob_ff[2] != 16'h0000);  // [RULE13]
  wire volt_armed = volt_en & (glob_ff[5] != 16'h0000); // [RULE13]
  // Set below threshold, held until the level climbs past the lower limit
  wire nxt_cur_fail  = cur_armed & ((cur_level < glob_ff[2]) |
                                    (cur_fail_ff & (cur_level <= glob_ff[0]))); // [RULE20] [RULE12]
  wire nxt_volt_fail = volt_armed & ((volt_level < glob_ff[5]) |
                                     (volt_fail_ff & (volt_level <= glob_ff[3]))); // [RULE20] [RULE12]

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur_fail_ff <= 1'b0;
    end else begin
      cur_fail_ff <= nxt_cur_fail;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      volt_fail_ff <= 1'b0;
    end else begin
      volt_fail_ff <= nxt_volt_fail;
    end
  end

  // ========================================================================
  // Speed curve segment search
  logic [2:0] seg;
  always_comb begin
    seg = 3'h0;
    // Point 0 is pinned at zero rpm, so search starts at point 1 [RULE16]
    for (int i = 1; i < 8; i++) begin
      if ((4'(i) < npts) && (engine_rpm >= sched_ff[act][`ITS_S_SPD0 + 5'(i)])) begin
        seg = 3'(i); // [RULE17] [RULE18]
      end
    end
  end

  wire        seg_last = (4'({1'b0, seg}) + 4'h1) >= npts;
  wire [2:0]  seg_nx   = seg_last ? seg : seg + 3'h1;
  wire [15:0] spd_a    = (seg == 3'h0) ? 16'h0000 : sched_ff[act][`ITS_S_SPD0 + 5'(seg)];
  wire [15:0] spd_b    = seg_last ? spd_a : sched_ff[act][`ITS_S_SPD0 + 5'(seg_nx)];

  // ========================================================================
  // Interpolators: 0 current, 1 voltage, 2 speed curve
  logic [15:0] ix  [3];
  logic [15:0] ix0 [3];
  logic [15:0] ix1 [3];
  its_deg_t    iy0 [3];
  its_deg_t    iy1 [3];
  its_deg_t    iy  [3];

  assign ix[0]  = cur_level;
  assign ix0[0] = glob_ff[0];
  assign ix1[0] = glob_ff[1];
  assign iy0[0] = its_deg_t'(sched_ff[act][`ITS_S_CUR_LO]);
  assign iy1[0] = its_deg_t'(sched_ff[act][`ITS_S_CUR_HI]);
  assign ix[1]  = volt_level;
  assign ix0[1] = glob_ff[3];
  assign ix1[1] = glob_ff[4];
  assign iy0[1] = its_deg_t'(sched_ff[act][`ITS_S_VOLT_LO]);
  assign iy1[1] = its_deg_t'(sched_ff[act][`ITS_S_VOLT_HI]);
  assign ix[2]  = engine_rpm;
  assign ix0[2] = spd_a;
  assign ix1[2] = spd_b;
  assign iy0[2] = its_deg_t'(sched_ff[act][`ITS_S_TIM0 + 5'(seg)]);
  assign iy1[2] = its_deg_t'(sched_ff[act][`ITS_S_TIM0 + 5'(seg_nx)]);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_interp
      its_interp u_interp (
        .x  (ix[g]),
        .x0 (ix0[g]),
        .x1 (ix1[g]),
        .y0 (iy0[g]),
        .y1 (iy1[g]),
        .y  (iy[g])
      ); // [RULE10] [RULE22]
    end
  endgenerate

  // Error value replaces the live adjustment while failed [RULE11]
  wire its_deg_t cur_adj  = cur_fail_ff  ? its_deg_t'(sched_ff[act][`ITS_S_CUR_ERR])  : iy[0];
  wire its_deg_t volt_adj = volt_fail_ff ? its_deg_t'(sched_ff[act][`ITS_S_VOLT_ERR]) : iy[1];

  // ========================================================================
  // Summation and window clamp
  wire its_deg_t p1 = its_deg_t'(sched_ff[act][`ITS_S_WIN_P1]);
  wire its_deg_t p2 = its_deg_t'(sched_ff[act][`ITS_S_WIN_P2]);
  // The window points may be entered in either order
  wire its_deg_t win_lo = (p1 < p2) ? p1 : p2;
  wire its_deg_t win_hi = (p1 < p2) ? p2 : p1;

  wire its_sum_t raw_sum =
      20'(its_deg_t'(sched_ff[act][`ITS_S_BASE]))          // [RULE7]
    + (pot_live_ff[act] ? 20'(pot_adj)  : 20'sh00000)       // [RULE8]
    + (cur_en           ? 20'(cur_adj)  : 20'sh00000)       // [RULE10]
    + (volt_en          ? 20'(volt_adj) : 20'sh00000)       // [RULE10]
    + (curve_en         ? 20'(iy[2])    : 20'sh00000);      // [RULE15] [RULE21]

  // Saturate rather than wrap so no adjustment escapes the window
  wire its_deg_t nxt_timing = (raw_sum < 20'(win_lo)) ? win_lo :
                              (raw_sum > 20'(win_hi)) ? win_hi :
                              its_deg_t'(raw_sum); // [RULE6]

  // ========================================================================
  // Per-cylinder firing points
  wire its_deg_t ind_adv = its_deg_t'(sched_ff[act][`ITS_S_IND_ADV]);
  wire its_deg_t ind_ret = its_deg_t'(sched_ff[act][`ITS_S_IND_RET]);
  wire its_deg_t neg_ret = its_deg_t'(-ind_ret);
  logic [NCYL*16-1:0] nxt_fire;

  generate
    for (g = 0; g < NCYL; g++) begin : g_cyl
      wire its_deg_t off_raw = its_deg_t'(cyl_offset[g*16 +: 16]);
      // Each cylinder's cyl_offset is bound by the same limits [RULE14]
      wire its_deg_t off_lim = (off_raw > ind_adv) ? ind_adv :
                               (off_raw < neg_ret) ? neg_ret : off_raw;
      wire its_sum_t cyl_sum = 20'(nxt_timing) + 20'(off_lim);
      assign nxt_fire[g*16 +: 16] = (cyl_sum < 20'(win_lo)) ? win_lo :
                                    (cyl_sum > 20'(win_hi)) ? win_hi :
                                    16'(cyl_sum); // [RULE5]
    end
  endgenerate

  // Outputs are registered so consumers see one settled value per clock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timing_ff <= 16'h0000;
    end else begin
      timing_ff <= nxt_timing;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fire_ff <= '0;
    end else begin
      fire_ff <= nxt_fire;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sched_b_ff <= 1'b0;
    end else begin
      sched_b_ff <= use_b;
    end
  end

  assign global_timing  = timing_ff;
  assign fire_point     = fire_ff;
  assign sched_b_active = sched_b_ff;
  assign cur_failed     = cur_fail_ff;
  assign volt_failed    = volt_fail_ff;

endmodule

/* sim/its_top_monitor.sv */
// Purpose: Port-level checks for its_top.
// Assumes: Shadows follow schedule A, B enable and current input globals.
// Notes:   Relations wait three quiet cycles after any register write.
module its_top_monitor
  import its_pkg::*;
#(
  parameter int NCYL = 4
)(
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic [7:0]         reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_rdata,
  input wire logic               sched_sel,
  input wire logic [15:0]        cur_level,
  input wire logic [15:0]        global_timing,
  input wire logic [NCYL*16-1:0] fire_point,
  input wire logic               sched_b_active,
  input wire logic               cur_failed
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Shadow configuration
  logic [15:0] ctrl_a_ff, cur_lo_ff, cur_thr_ff;
  logic        b_en_ff, win_ok_ff;
  its_deg_t    p1_ff, p2_ff, adv_ff, ret_ff;
  logic [1:0]  quiet_ff;
  wire its_deg_t lo_w   = (p1_ff < p2_ff) ? p1_ff : p2_ff;
  wire its_deg_t hi_w   = (p1_ff < p2_ff) ? p2_ff : p1_ff;
  wire its_deg_t gt_w   = global_timing;
  wire its_deg_t fp_w   = fire_point[15:0];
  wire its_sum_t df_w   = its_sum_t'(fp_w) - its_sum_t'(gt_w);
  wire logic     a_on_w = quiet_ff == 2'h3 && !sched_b_active && win_ok_ff;
  wire logic     c_on_w = quiet_ff == 2'h3 && !b_en_ff && ctrl_a_ff[2] && cur_thr_ff != 16'h0;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {ctrl_a_ff, cur_lo_ff, cur_thr_ff} <= {16'h0001, 16'h0FA0, 16'h0000};
      {p1_ff, p2_ff, adv_ff, ret_ff} <= 64'h0;
      {b_en_ff, win_ok_ff, quiet_ff} <= 4'h0;
    end else begin
      quiet_ff <= reg_wr ? 2'h0 : (quiet_ff == 2'h3 ? 2'h3 : quiet_ff + 2'h1);
      win_ok_ff <= win_ok_ff | (reg_wr && reg_addr == 8'h02);
      if (reg_wr) begin
        case (reg_addr)
          8'h00: ctrl_a_ff <= reg_wdata;
          8'h01: p1_ff <= reg_wdata;
          8'h02: p2_ff <= reg_wdata;
          8'h0C: adv_ff <= reg_wdata;
          8'h0D: ret_ff <= reg_wdata;
          8'h40: b_en_ff <= reg_wdata[0];
          8'h80: cur_lo_ff <= reg_wdata;
          8'h82: cur_thr_ff <= reg_wdata;
          default: ;
        endcase
      end
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================================
  // Assertions
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data not zero outside a read");
  AST_CTRL_READ: assert property ($past(reg_rd) && $past(reg_addr) == 8'h00
    |-> reg_rdata == ctrl_a_ff) else $error("control word read back wrong");
  AST_SCHED_PICK: assert property (quiet_ff == 2'h3 |->
    sched_b_active == (b_en_ff && (!ctrl_a_ff[0] || $past(sched_sel))))
    else $error("wrong schedule in use");
  AST_GLOBAL_WIN: assert property (a_on_w |-> gt_w >= lo_w && gt_w <= hi_w)
    else $error("global timing outside window");
  AST_FIRE_WIN: assert property (a_on_w |-> fp_w >= lo_w && fp_w <= hi_w)
    else $error("firing point outside window");
  AST_FIRE_OFS: assert property (a_on_w |-> df_w <= adv_ff && df_w >= -ret_ff)
    else $error("cylinder offset beyond its limits");
  AST_NO_THR: assert property (quiet_ff == 2'h3 && cur_thr_ff == 16'h0 |-> !cur_failed)
    else $error("failure flagged without threshold");
  AST_FAIL_SET: assert property (c_on_w && $past(cur_level) < cur_thr_ff
    |-> cur_failed) else $error("low current not flagged");
  AST_FAIL_HOLD: assert property (c_on_w && cur_failed && cur_level <= cur_lo_ff
    |=> cur_failed) else $error("failure dropped too early");
  AST_FAIL_CLEAR: assert property (c_on_w && $past(cur_level) > cur_lo_ff
    && $past(cur_level) >= cur_thr_ff |-> !cur_failed) else $error("failure not cleared");
  COV_FAIL: cover property ($rose(cur_failed));
  COV_SCHED_B: cover property ($rose(sched_b_active));
  COV_CLAMP: cover property (a_on_w && gt_w == hi_w);
endmodule

bind its_top its_top_monitor #(.NCYL(NCYL)) u_its_top_monitor (.mclk, .rst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sched_sel, .cur_level, .global_timing,
  .fire_point, .sched_b_active, .cur_failed);

/* sim/its_field.sv */
// Purpose: Engine-side sources: select switch, pot, analog levels, speed, offsets.
// Assumes: Levels change only just after a clock edge.
// Notes:   Levels are steady values, so nothing is released between changes.
module its_field (
  input  wire logic        mclk,
  output logic             sched_sel,
  output logic signed [7:0] pot_pos,
  output logic [15:0]      cur_level,
  output logic [15:0]      volt_level,
  output logic [15:0]      engine_rpm,
  output logic [63:0]      cyl_offset
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {sched_sel, pot_pos, cur_level, volt_level, engine_rpm, cyl_offset} = '0;
  task automatic env(input logic s, input logic [7:0] p, input logic [15:0] c, v, r);
    @(posedge mclk);
    {sched_sel, pot_pos, cur_level, volt_level, engine_rpm} <= {s, p, c, v, r};
  endtask
  task automatic ofs(input logic [63:0] o);
    @(posedge mclk);
    cyl_offset <= o;
  endtask
endmodule

/* sim/its_top_bench.sv */
// Purpose: Self-checking bench for its_top.
// Assumes: Angles in 0.1 degree, advance positive.
// Notes:   Timing outputs are read three cycles after each change.
module its_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [15:0]       reg_wdata = 16'h0000;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [15:0]       reg_rdata, global_timing, cur_level, volt_level, engine_rpm;
  logic [63:0]       fire_point, cyl_offset;
  logic signed [7:0] pot_pos;
  logic              sched_sel, sched_b_active, cur_failed, volt_failed;
  int                n_mismatch = 0;
  int                compares = 0;
  int                cyc = 0;
  logic [15:0]       rpm_t [4] = '{16'h0019, 16'h0032, 16'h020D, 16'h07D0};
  logic [15:0]       exp_t [4] = '{16'h00AF, 16'h0096, 16'h00AF, 16'h00C8};
  always #20 mclk = ~mclk;
  its_top #(.NCYL(4)) u_its_top (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sched_sel, .pot_pos, .cur_level, .volt_level, .engine_rpm, .cyl_offset,
    .global_timing, .fire_point, .sched_b_active, .cur_failed, .volt_failed);
  its_field u_its_field (.mclk, .sched_sel, .pot_pos, .cur_level, .volt_level,
    .engine_rpm, .cyl_offset);
  // ==========================================================================
  // Access and compare tasks
  task automatic chk(input string nm, input logic [15:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic tg(input logic [15:0] e);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    chk("global_timing", e, global_timing);
  endtask
  task automatic give_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Sequence
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h00, 16'h0001);
    rd(8'h40, 16'h0000);
    rd(8'h80, 16'h0FA0);
    rd(8'h81, 16'h4E20);
    rd(8'h84, 16'h1388);
    rd(8'h82, 16'h0000);
    rd(8'h20, 16'h0000);
    wr(8'h01, 16'h012C);
    wr(8'h02, 16'h0032);
    wr(8'h03, 16'h00C8);
    wr(8'h0C, 16'h0014);
    wr(8'h0D, 16'h0014);
    tg(16'h00C8);
    wr(8'h86, 16'h1234);
    rd(8'h86, 16'h00C8);
    wr(8'h03, 16'h0190);
    tg(16'h012C);
    wr(8'h03, 16'h0014);
    tg(16'h0032);
    wr(8'h03, 16'h00C8);
    u_its_field.ofs(64'h0000_0005_FFCE_0032);
    tg(16'h00C8);
    chk("fire_point0", 16'h00DC, fire_point[15:0]);
    chk("fire_point1", 16'h00B4, fire_point[31:16]);
    chk("fire_point2", 16'h00CD, fire_point[47:32]);
    chk("fire_point3", 16'h00C8, fire_point[63:48]);
    wr(8'h03, 16'h0122);
    tg(16'h0122);
    chk("fire_point0", 16'h012C, fire_point[15:0]);
    wr(8'h03, 16'h00C8);
    u_its_field.ofs(64'h0);
    wr(8'h42, 16'h012C);
    wr(8'h43, 16'h0064);
    wr(8'h40, 16'h0001);
    u_its_field.env(1'b1, 8'h00, 16'h0000, 16'h0000, 16'h0000);
    tg(16'h0064);
    chk("sched_b_active", 16'h0001, 16'(sched_b_active));
    u_its_field.env(1'b0, 8'h00, 16'h0000, 16'h0000, 16'h0000);
    tg(16'h00C8);
    wr(8'h00, 16'h0000);
    tg(16'h0064);
    wr(8'h00, 16'h0001);
    wr(8'h40, 16'h0000);
    u_its_field.env(1'b1, 8'h00, 16'h0000, 16'h0000, 16'h0000);
    tg(16'h00C8);
    wr(8'h06, 16'h000A);
    wr(8'h07, 16'hFFBA);
    wr(8'h08, 16'hFFD8);
    wr(8'h00, 16'h0005);
    u_its_field.env(1'b0, 8'h00, 16'h2EE0, 16'h0000, 16'h0000);
    tg(16'h00AA);
    u_its_field.env(1'b0, 8'h00, 16'h0000, 16'h0000, 16'h0000);
    tg(16'h00D2);
    chk("cur_failed", 16'h0000, 16'(cur_failed));
    wr(8'h82, 16'h0C80);
    u_its_field.env(1'b0, 8'h00, 16'h0BB8, 16'h0000, 16'h0000);
    tg(16'h00A0);
    chk("cur_failed", 16'h0001, 16'(cur_failed));
    rd(8'h87, 16'h0004);
    u_its_field.env(1'b0, 8'h00, 16'h0DAC, 16'h0000, 16'h0000);
    tg(16'h00A0);
    u_its_field.env(1'b0, 8'h00, 16'h1F40, 16'h0000, 16'h0000);
    tg(16'h00BE);
    chk("cur_failed", 16'h0000, 16'(cur_failed));
    wr(8'h83, 16'h07D0);
    wr(8'h0A, 16'hFFBA);
    wr(8'h0B, 16'h001E);
    wr(8'h00, 16'h0009);
    u_its_field.env(1'b0, 8'h00, 16'h0000, 16'h0DAC, 16'h0000);
    tg(16'h00A5);
    wr(8'h85, 16'h03E8);
    u_its_field.env(1'b0, 8'h00, 16'h0000, 16'h01F4, 16'h0000);
    tg(16'h00E6);
    chk("volt_failed", 16'h0001, 16'(volt_failed));
    wr(8'h00, 16'h0211);
    wr(8'h10, 16'h007B);
    rd(8'h10, 16'h0000);
    wr(8'h11, 16'h0032);
    wr(8'h12, 16'h03E8);
    wr(8'h19, 16'hFFCE);
    wr(8'h1A, 16'h0000);
    foreach (rpm_t[i]) begin
      u_its_field.env(1'b0, 8'h00, 16'h0000, 16'h0000, rpm_t[i]);
      tg(exp_t[i]);
    end
    wr(8'h00, 16'h0011);
    tg(16'h00C8);
    wr(8'h04, 16'h0032);
    wr(8'h05, 16'hFFCE);
    wr(8'h00, 16'h0003);
    u_its_field.env(1'b0, 8'h40, 16'h0000, 16'h0000, 16'h0000);
    tg(16'h00E1);
    u_its_field.env(1'b0, 8'h80, 16'h0000, 16'h0000, 16'h03E8);
    tg(16'h0096);
    wr(8'h00, 16'h0001);
    tg(16'h0096);
    u_its_field.env(1'b0, 8'h80, 16'h0000, 16'h0000, 16'h0000);
    tg(16'h00C8);
    give_verdict();
  end
endmodule
